// file: bench/serial_peer_model.sv
// far-side controller: sends command lines, takes transmitted bytes
// assumes bench calls send_line and reads ser_q and net_q by hierarchy
`timescale 1ns/1ps
module serial_peer_model (
   input  wire logic       core_clk,
   output logic [7:0]      ser_rx_data,
   output logic            ser_rx_valid,
   output logic [7:0]      net_rx_data,
   output logic            net_rx_valid,
   input  wire logic [7:0] ser_tx_data_r,
   input  wire logic       ser_tx_valid_r,
   output logic            ser_tx_ready,
   input  wire logic [7:0] net_tx_data_r,
   input  wire logic       net_tx_valid_r,
   output logic            net_tx_ready,
   input  wire logic       slow,
   input  wire logic       hold
);
   logic [7:0] ser_q[$];
   logic [7:0] net_q[$];
   initial begin
      {ser_rx_data, ser_rx_valid, net_rx_data, net_rx_valid} = '0;
      {ser_tx_ready, net_tx_ready} = '0;
   end
   // stalls: hold blocks, slow accepts every other cycle
   always @(negedge core_clk) begin
      ser_tx_ready <= !hold && (!slow || !ser_tx_ready);
      net_tx_ready <= !hold && (!slow || !net_tx_ready);
   end
   always @(posedge core_clk) begin
      if (ser_tx_valid_r && ser_tx_ready)
         ser_q.push_back(ser_tx_data_r);
      if (net_tx_valid_r && net_tx_ready)
         net_q.push_back(net_tx_data_r);
   end
   task automatic put(input bit net, input logic [7:0] b, input logic v);
      if (net) begin
         net_rx_data = b;
         net_rx_valid = v;
      end else begin
         ser_rx_data = b;
         ser_rx_valid = v;
      end
      @(negedge core_clk);
   endtask
   task automatic send_line(input bit net, input string s);
      foreach (s[i]) put(net, s[i], 1'b1);
      put(net, 8'h0d, 1'b1);
      // released data shows the inverse of the last byte
      put(net, 8'hf2, 1'b0);
   endtask
endmodule

// file: bench/serial_string_engine_bench.sv
// self-checking bench for the serial string matcher and sender
// assumes serial_peer_model as the far side on both ports
`timescale 1ns/1ps
module serial_string_engine_bench;
   logic       core_clk, srst, clear_all, def_start, def_is_tx, def_hex_mode;
   logic       def_char_valid, def_end, rx_test, preset_recall, general_input_event;
   logic       logic_event, tx_test, tx_to_net, online, action_valid_r, action_on_r;
   logic       tx_busy_r, ser_rx_valid, net_rx_valid, ser_tx_valid_r, net_tx_valid_r;
   logic       ser_tx_ready, net_tx_ready, peer_slow, peer_hold, act_on;
   logic [6:0] def_entry, rx_test_entry;
   logic [7:0] def_char, ser_rx_data, net_rx_data, ser_tx_data_r, net_tx_data_r;
   logic [5:0] tx_entry, action_pair_r, act_pair;
   int         fail_count, cmp_count, act_count, cyc;

   serial_string_engine DUT (.core_clk(core_clk), .srst(srst), .ser_rx_data(ser_rx_data),
      .ser_rx_valid(ser_rx_valid), .net_rx_data(net_rx_data), .net_rx_valid(net_rx_valid),
      .clear_all(clear_all), .def_start(def_start), .def_is_tx(def_is_tx), .def_entry(def_entry),
      .def_hex_mode(def_hex_mode), .def_char(def_char), .def_char_valid(def_char_valid),
      .def_end(def_end), .rx_test(rx_test), .rx_test_entry(rx_test_entry),
      .preset_recall(preset_recall), .general_input_event(general_input_event),
      .logic_event(logic_event), .tx_test(tx_test), .tx_entry(tx_entry), .tx_to_net(tx_to_net),
      .online(online), .action_valid_r(action_valid_r), .action_pair_r(action_pair_r),
      .action_on_r(action_on_r), .tx_busy_r(tx_busy_r), .ser_tx_data_r(ser_tx_data_r),
      .ser_tx_valid_r(ser_tx_valid_r), .ser_tx_ready(ser_tx_ready), .net_tx_data_r(net_tx_data_r),
      .net_tx_valid_r(net_tx_valid_r), .net_tx_ready(net_tx_ready));

   serial_peer_model peer (.core_clk(core_clk), .ser_rx_data(ser_rx_data),
      .ser_rx_valid(ser_rx_valid), .net_rx_data(net_rx_data), .net_rx_valid(net_rx_valid),
      .ser_tx_data_r(ser_tx_data_r), .ser_tx_valid_r(ser_tx_valid_r), .ser_tx_ready(ser_tx_ready),
      .net_tx_data_r(net_tx_data_r), .net_tx_valid_r(net_tx_valid_r), .net_tx_ready(net_tx_ready),
      .slow(peer_slow), .hold(peer_hold));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (action_valid_r === 1'b1) begin
         act_count++;
         act_pair = action_pair_r;
         act_on = action_on_r;
      end
      if (cyc == 60000) begin
         fail_count++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input bit bad, input string m);
      cmp_count++;
      if (bad) begin
         fail_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   function automatic string rep(input int n, input string c);
      string r;
      r = "";
      repeat (n) r = {r, c};
      return r;
   endfunction

   task automatic def_str(input bit tx, input int ent, input bit hex, input string s);
      {def_is_tx, def_entry, def_hex_mode, def_start} = {tx, 7'(ent), hex, 1'b1};
      tick(1);
      def_start = 1'b0;
      foreach (s[i]) begin
         {def_char, def_char_valid} = {s[i], 1'b1};
         tick(1);
      end
      {def_char_valid, def_end} = 2'b01;
      tick(1);
      def_end = 1'b0;
      tick(1);
   endtask

   // waits for a scan to finish, then judges presence and target of an action
   task automatic expect_act(input int n0, input logic [5:0] p, input logic on, input bit want);
      for (int i = 0; i < 300 && act_count == n0; i++) tick(1);
      tick(300 - (act_count == n0 ? 300 : 0) + 5);
      check((act_count != n0) != want, "action presence wrong");
      if (want)
         check({act_pair, act_on} !== {p, on}, "action pair or side wrong");
   endtask

   task automatic line(input bit net, input string s, input logic [5:0] p, input logic on,
                       input bit want);
      int n0;
      n0 = act_count;
      peer.send_line(net, s);
      expect_act(n0, p, on, want);
   endtask

   task automatic fire(input int kind, input int ent, input bit net);
      {tx_entry, tx_to_net} = {6'(ent), net};
      case (kind)
         0: preset_recall = 1'b1;
         1: general_input_event = 1'b1;
         2: logic_event = 1'b1;
         default: tx_test = 1'b1;
      endcase
      tick(1);
      {preset_recall, general_input_event, logic_event, tx_test} = 4'h0;
   endtask

   task automatic expect_bytes(input bit net, input string s);
      for (int i = 0; i < 600 && (net ? peer.net_q.size() : peer.ser_q.size()) < s.len(); i++)
         tick(1);
      tick(30);
      check((net ? peer.net_q.size() : peer.ser_q.size()) != s.len(), "byte count wrong");
      foreach (s[k])
         check((net ? peer.net_q[k] : peer.ser_q[k]) !== s[k], "byte value wrong");
      peer.ser_q.delete();
      peer.net_q.delete();
   endtask

   task automatic t_match();
      def_str(1'b0, 0, 1'b0, "ON1");
      def_str(1'b0, 3, 1'b0, "OFF2");
      line(1'b0, "OFF2", 6'h01, 1'b0, 1'b1);
      line(1'b1, "ON1", 6'h00, 1'b1, 1'b1);
      line(1'b0, "ON", 6'h00, 1'b0, 1'b0);
   endtask

   task automatic t_long();
      int n0;
      def_str(1'b0, 127, 1'b0, rep(64, "x"));
      line(1'b0, rep(64, "x"), 6'h3f, 1'b0, 1'b1);
      line(1'b1, rep(65, "x"), 6'h00, 1'b0, 1'b0);
      line(1'b1, "ON1", 6'h00, 1'b1, 1'b1);
      n0 = act_count;
      {rx_test, rx_test_entry} = {1'b1, 7'h03};
      tick(1);
      rx_test = 1'b0;
      expect_act(n0, 6'h01, 1'b0, 1'b1);
   endtask

   task automatic t_send();
      peer_slow = 1'b1;
      def_str(1'b1, 5, 1'b0, "A\\0dB");
      def_str(1'b1, 63, 1'b1, "\\30");
      for (int k = 0; k < 3; k++) begin
         fire(k, 5, k[0]);
         expect_bytes(k[0], "A\015B");
      end
      fire(1, 63, 1'b0);
      expect_bytes(1'b0, "\\30");
      peer_slow = 1'b0;
   endtask

   task automatic t_buffer();
      def_str(1'b1, 0, 1'b0, rep(40, "k"));
      peer_hold = 1'b1;
      fire(2, 0, 1'b0);
      tick(100);
      check(peer.ser_q.size() != 0 || ser_tx_valid_r !== 1'b1 || tx_busy_r !== 1'b1, "valid or busy not held");
      peer_hold = 1'b0;
      expect_bytes(1'b0, rep(40, "k"));
      check(tx_busy_r !== 1'b0, "busy after send");
   endtask

   task automatic t_offline();
      online = 1'b0;
      fire(3, 5, 1'b1);
      expect_bytes(1'b1, "");
      online = 1'b1;
      fire(3, 5, 1'b1);
      expect_bytes(1'b1, "A\015B");
   endtask

   task automatic t_clear();
      def_str(1'b0, 0, 1'b0, "NEW");
      line(1'b0, "ON1", 6'h00, 1'b1, 1'b0);
      line(1'b0, "NEW", 6'h00, 1'b1, 1'b1);
      clear_all = 1'b1;
      tick(1);
      clear_all = 1'b0;
      line(1'b0, "NEW", 6'h00, 1'b1, 1'b0);
      fire(1, 5, 1'b0);
      expect_bytes(1'b0, "");
   endtask

   initial begin
      {clear_all, def_start, def_is_tx, def_hex_mode, def_char_valid, def_end} = 6'h00;
      {rx_test, preset_recall, general_input_event, logic_event, tx_test, tx_to_net} = 6'h00;
      {def_entry, rx_test_entry, def_char, tx_entry} = '0;
      {peer_slow, peer_hold, online, srst} = 4'h3;
      {fail_count, cmp_count, act_count, cyc} = '0;
      tick(5);
      srst = 1'b0;
      tick(1);
      check({action_valid_r, tx_busy_r, ser_tx_valid_r, net_tx_valid_r} !== 4'h0, "reset outputs");
      t_match();
      t_long();
      t_send();
      t_buffer();
      t_offline();
      t_clear();
      wrap_up();
   end
endmodule

// file: rtl/byte_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;
   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// file: rtl/serial_string_engine.sv
// serial command string matcher and sender
// assumes synchronous byte links on serial and network ports
`timescale 1ns/1ps
`include "string_engine_params.svh"
// Notes on behaviour
// R1: lines from serial or network port are matched identically
// R2: receive table holds 128 strings as 64 on/off pairs
// R3: each receive string holds at most 64 characters
// R4: a matching line fires the on or off action of that pair
// R5: carriage return ends a line and is not compared
// R6: the sender appends no carriage return; a command needing one stores it as \0d
// R7: a receive test trigger fires the same action as a match
// R8: clear-all erases every entry; a load overwrites all
// R9: transmit table holds 64 strings as 32 on/off pairs
// R10: transmit strings hold at most 64 bytes, sent to either port
// R11: preset recall, input event or logic function starts sending
// R12: exactly the stored bytes are sent, nothing appended
// R13: backslash and two hex digits store one byte; the code decodes this only in transmit strings with def_hex_mode low
// R14: transmit test triggers act only while online
// R15: overlong lines are dropped until the next carriage return
module serial_string_engine #(
   parameter int MAX_CHARS  = `SE_MAX_CHARS,
   parameter int FIFO_DEPTH = `SE_FIFO_DEPTH
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [7:0] ser_rx_data,
   input  wire logic       ser_rx_valid,
   input  wire logic [7:0] net_rx_data,
   input  wire logic       net_rx_valid,
   input  wire logic       clear_all,
   input  wire logic       def_start,
   input  wire logic       def_is_tx,
   input  wire logic [6:0] def_entry,
   input  wire logic       def_hex_mode,
   input  wire logic [7:0] def_char,
   input  wire logic       def_char_valid,
   input  wire logic       def_end,
   input  wire logic       rx_test,
   input  wire logic [6:0] rx_test_entry,
   input  wire logic       preset_recall,
   input  wire logic       general_input_event,
   input  wire logic       logic_event,
   input  wire logic       tx_test,
   input  wire logic [5:0] tx_entry,
   input  wire logic       tx_to_net,
   input  wire logic       online,
   output logic            action_valid_r,
   output logic [5:0]      action_pair_r,
   output logic            action_on_r,
   output logic            tx_busy_r,
   output logic [7:0]      ser_tx_data_r,
   output logic            ser_tx_valid_r,
   input  wire logic       ser_tx_ready,
   output logic [7:0]      net_tx_data_r,
   output logic            net_tx_valid_r,
   input  wire logic       net_tx_ready
);
   // tables: entry index = pair*2 + (off ? 1 : 0)
   logic [7:0] rx_tab [`SE_RX_ENTRIES][MAX_CHARS];
   logic [6:0] rx_len [`SE_RX_ENTRIES];
   logic [7:0] tx_tab [`SE_TX_ENTRIES][MAX_CHARS]; // R9
   logic [6:0] tx_len [`SE_TX_ENTRIES];
   string_engine_pkg::rx_state_t  rx_st_r;
   string_engine_pkg::tx_state_t  tx_st_r;
   string_engine_pkg::def_state_t def_st_r;
   logic [7:0] byte_in;
   logic       byte_in_valid;
   logic [5:0] rd_idx;
   logic [7:0] rd_char;
   logic [6:0] line_len;
   logic       line_done;
   logic       line_ack;
   logic [6:0] scan_ent_r;
   logic [6:0] def_pos_r;
   logic [3:0] hex_hi_r;
   logic       def_wr;
   logic [7:0] def_byte;
   logic [6:0] tx_pos_r;
   logic [5:0] tx_ent_r;
   logic       tx_net_r;
   logic       tx_req;
   logic       fifo_in_ready;
   logic [8:0] fifo_out_data;
   logic       fifo_out_valid;
   logic       fifo_out_ready;
   logic       entry_eq;
   function automatic logic [3:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) begin
         hex_val = 4'(c - 8'h30);
      end else if (c >= 8'h61 && c <= 8'h66) begin
         hex_val = 4'(c - 8'h57);
      end else if (c >= 8'h41 && c <= 8'h46) begin
         hex_val = 4'(c - 8'h37);
      end else begin
         hex_val = 4'h0;
      end
   endfunction
   // serial port has priority when both ports deliver together
   assign byte_in       = ser_rx_valid ? ser_rx_data : net_rx_data; // R1
   assign byte_in_valid = ser_rx_valid || net_rx_valid; // R1
   assign rd_idx        = '0;
   string_receiver #(
      .MAX_CHARS (MAX_CHARS)
   ) u_rx (
      .core_clk    (core_clk),
      .srst        (srst),
      .rx_byte     (byte_in),
      .rx_valid    (byte_in_valid),
      .rd_idx      (rd_idx),
      .rd_char     (rd_char),
      .line_len_r  (line_len),
      .line_done_r (line_done),
      .line_ack    (line_ack)
   );
   // whole-entry compare against the captured line
   always_comb begin
      entry_eq = (rx_len[scan_ent_r] == line_len) && (line_len != '0);
      for (int i = 0; i < MAX_CHARS; i++) begin
         if (7'(i) < line_len && rx_tab[scan_ent_r][i] != u_rx.line_mem[i]) begin
            entry_eq = 1'b0;
         end
      end
   end
   assign line_ack = (rx_st_r == string_engine_pkg::RX_SCAN) &&
                     (entry_eq || scan_ent_r == 7'(`SE_RX_ENTRIES-1));
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_st_r    <= string_engine_pkg::RX_COLLECT;
         scan_ent_r <= '0;
      end else begin
         case (rx_st_r)
            string_engine_pkg::RX_COLLECT: begin
               scan_ent_r <= '0;
               if (line_done) begin
                  rx_st_r <= string_engine_pkg::RX_SCAN;
               end
            end
            string_engine_pkg::RX_SCAN: begin
               if (line_ack) begin
                  rx_st_r <= string_engine_pkg::RX_COLLECT;
               end else begin
                  scan_ent_r <= scan_ent_r + 7'd1; // R2
               end
            end
            default: rx_st_r <= string_engine_pkg::RX_COLLECT;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         action_valid_r <= 1'b0;
         action_pair_r  <= '0;
         action_on_r    <= 1'b0;
      end else if (rx_st_r == string_engine_pkg::RX_SCAN && entry_eq) begin
         action_valid_r <= 1'b1; // R4
         action_pair_r  <= scan_ent_r[6:1];
         action_on_r    <= !scan_ent_r[0];
      end else if (rx_test) begin
         action_valid_r <= 1'b1; // R7
         action_pair_r  <= rx_test_entry[6:1];
         action_on_r    <= !rx_test_entry[0];
      end else begin
         action_valid_r <= 1'b0;
      end
   end
   // definition loader; hex escapes only decoded for transmit text
   always_comb begin
      def_wr   = 1'b0;
      def_byte = def_char;
      if (def_char_valid) begin
         case (def_st_r)
            string_engine_pkg::DEF_TEXT: begin
               if (def_hex_mode || !(def_is_tx && def_char == `SE_CHAR_BSL)) begin
                  def_wr = 1'b1;
               end
            end
            string_engine_pkg::DEF_HEX2: begin
               def_wr   = 1'b1; // R13
               def_byte = {hex_hi_r, hex_val(def_char)};
            end
            default: def_wr = 1'b0;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         def_st_r  <= string_engine_pkg::DEF_TEXT;
         def_pos_r <= '0;
         hex_hi_r  <= '0;
      end else if (def_start) begin
         def_st_r  <= string_engine_pkg::DEF_TEXT;
         def_pos_r <= '0;
      end else if (def_char_valid) begin
         case (def_st_r)
            string_engine_pkg::DEF_TEXT: begin
               if (!def_wr) begin
                  def_st_r <= string_engine_pkg::DEF_HEX1; // R13
               end
            end
            string_engine_pkg::DEF_HEX1: begin
               hex_hi_r <= hex_val(def_char);
               def_st_r <= string_engine_pkg::DEF_HEX2;
            end
            default: def_st_r <= string_engine_pkg::DEF_TEXT;
         endcase
         if (def_wr && def_pos_r < 7'(MAX_CHARS)) begin
            def_pos_r <= def_pos_r + 7'd1; // R3 R10
         end
      end
   end
   always_ff @(posedge core_clk) begin
      if (def_wr && def_pos_r < 7'(MAX_CHARS)) begin
         if (def_is_tx) begin
            tx_tab[def_entry[5:0]][def_pos_r[5:0]] <= def_byte;
         end else begin
            rx_tab[def_entry][def_pos_r[5:0]] <= def_byte;
         end
      end
   end
   // a definition replaces the entry; clear-all empties both tables
   always_ff @(posedge core_clk) begin
      if (srst || clear_all) begin
         for (int i = 0; i < `SE_RX_ENTRIES; i++) begin
            rx_len[i] <= '0; // R8
         end
         for (int i = 0; i < `SE_TX_ENTRIES; i++) begin
            tx_len[i] <= '0; // R8
         end
      end else if (def_start) begin
         if (def_is_tx) begin
            tx_len[def_entry[5:0]] <= '0; // R8
         end else begin
            rx_len[def_entry] <= '0;
         end
      end else if (def_end) begin
         if (def_is_tx) begin
            tx_len[def_entry[5:0]] <= def_pos_r;
         end else begin
            rx_len[def_entry] <= def_pos_r;
         end
      end
   end
   assign tx_req = preset_recall || general_input_event || logic_event || (tx_test && online); // R11 R14
   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_st_r   <= string_engine_pkg::TX_IDLE;
         tx_pos_r  <= '0;
         tx_ent_r  <= '0;
         tx_net_r  <= 1'b0;
         tx_busy_r <= 1'b0;
      end else begin
         case (tx_st_r)
            string_engine_pkg::TX_IDLE: begin
               tx_pos_r <= '0;
               if (tx_req && tx_len[tx_entry] != '0) begin
                  tx_st_r   <= string_engine_pkg::TX_SEND;
                  tx_ent_r  <= tx_entry;
                  tx_net_r  <= tx_to_net; // R10
                  tx_busy_r <= 1'b1;
               end
            end
            string_engine_pkg::TX_SEND: begin
               if (fifo_in_ready) begin
                  tx_pos_r <= tx_pos_r + 7'd1;
                  if (tx_pos_r + 7'd1 >= tx_len[tx_ent_r]) begin
                     tx_st_r   <= string_engine_pkg::TX_IDLE; // R12
                     tx_busy_r <= 1'b0;
                  end
               end
            end
            default: tx_st_r <= string_engine_pkg::TX_IDLE;
         endcase
      end
   end
   byte_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .srst      (srst),
      .in_data   ({tx_net_r, tx_tab[tx_ent_r][tx_pos_r[5:0]]}),
      .in_valid  (tx_st_r == string_engine_pkg::TX_SEND),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready)
   );
   // port choice travels with each byte, so queued bytes keep their port
   assign fifo_out_ready = fifo_out_valid &&
                           (fifo_out_data[8] ? (!net_tx_valid_r || net_tx_ready) : (!ser_tx_valid_r || ser_tx_ready));
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ser_tx_valid_r <= 1'b0;
         ser_tx_data_r  <= '0;
         net_tx_valid_r <= 1'b0;
         net_tx_data_r  <= '0;
      end else begin
         if (ser_tx_ready) begin
            ser_tx_valid_r <= 1'b0;
         end
         if (net_tx_ready) begin
            net_tx_valid_r <= 1'b0;
         end
         if (fifo_out_ready && !fifo_out_data[8]) begin
            ser_tx_valid_r <= 1'b1; // R10
            ser_tx_data_r  <= fifo_out_data[7:0];
         end
         if (fifo_out_ready && fifo_out_data[8]) begin
            net_tx_valid_r <= 1'b1;
            net_tx_data_r  <= fifo_out_data[7:0];
         end
      end
   end
   property p_test_action;
      @(posedge core_clk) disable iff (srst)
      (rx_test && rx_st_r != string_engine_pkg::RX_SCAN) |=> action_valid_r && action_pair_r == $past(rx_test_entry[6:1]);
   endproperty
   a_test_action: assert property (p_test_action) else $error("test trigger gave no action"); // R7
   property p_offline;
      @(posedge core_clk) disable iff (srst)
      (tx_st_r == string_engine_pkg::TX_IDLE && tx_test && !online && !preset_recall
       && !general_input_event && !logic_event) |=> !tx_busy_r;
   endproperty
   a_offline: assert property (p_offline) else $error("offline test started a send"); // R14
   property p_clear;
      @(posedge core_clk) disable iff (srst)
      clear_all |=> tx_len[0] == '0 && rx_len[0] == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left an entry"); // R8
   property p_scan_bound;
      @(posedge core_clk) disable iff (srst)
      line_done |-> ##[0:130] !line_done;
   endproperty
   a_scan_bound: assert property (p_scan_bound) else $error("scan did not finish"); // R2
   property p_len_limit;
      @(posedge core_clk) disable iff (srst)
      line_done |-> line_len <= 7'(MAX_CHARS);
   endproperty
   a_len_limit: assert property (p_len_limit) else $error("line too long"); // R3
   property p_start_send;
      @(posedge core_clk) disable iff (srst)
      (tx_st_r == string_engine_pkg::TX_IDLE && general_input_event && tx_len[tx_entry] != '0) |=> tx_busy_r;
   endproperty
   a_start_send: assert property (p_start_send) else $error("event did not start send"); // R11
   property p_no_extra;
      @(posedge core_clk) disable iff (srst)
      tx_st_r == string_engine_pkg::TX_SEND |-> tx_pos_r < tx_len[tx_ent_r];
   endproperty
   a_no_extra: assert property (p_no_extra) else $error("sent past stored length"); // R12
   property p_match_on;
      @(posedge core_clk) disable iff (srst)
      (rx_st_r == string_engine_pkg::RX_SCAN && entry_eq) |=> action_valid_r && action_on_r == !$past(scan_ent_r[0]);
   endproperty
   a_match_on: assert property (p_match_on) else $error("wrong action side"); // R4
endmodule

// file: rtl/string_engine_params.svh
// constants for the serial string matcher and sender
// assumes inclusion by bare name from rtl files
`ifndef STRING_ENGINE_PARAMS_SVH
`define STRING_ENGINE_PARAMS_SVH
`define SE_RX_ENTRIES    128
`define SE_RX_PAIRS      64
`define SE_TX_ENTRIES    64
`define SE_TX_PAIRS      32
`define SE_MAX_CHARS     64
`define SE_CHAR_CR       8'h0d
`define SE_CHAR_BSL      8'h5c
`define SE_FIFO_DEPTH    16
`endif

// file: rtl/string_engine_pkg.sv
// types for the serial string matcher and sender
// no surroundings assumed
package string_engine_pkg;
   typedef enum logic [1:0] {
      RX_COLLECT = 2'b00,
      RX_SCAN    = 2'b01,
      RX_SKIP    = 2'b10
   } rx_state_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01
   } tx_state_t;
   typedef enum logic [1:0] {
      DEF_TEXT = 2'b00,
      DEF_HEX1 = 2'b01,
      DEF_HEX2 = 2'b10
   } def_state_t;
endpackage

// file: rtl/string_receiver.sv
// collects one line from a byte source up to carriage return
// assumes bytes arrive one per cycle at most, single clock
`timescale 1ns/1ps
`include "string_engine_params.svh"
module string_receiver #(
   parameter int MAX_CHARS = `SE_MAX_CHARS
) (
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [7:0] rx_byte,
   input  wire logic       rx_valid,
   input  wire logic [5:0] rd_idx,
   output logic [7:0]      rd_char,
   output logic [6:0]      line_len_r,
   output logic            line_done_r,
   input  wire logic       line_ack
);
   logic [7:0] line_mem [MAX_CHARS];
   logic [6:0] fill_r;
   logic       overflow_r;
   assign rd_char = line_mem[rd_idx];
   always_ff @(posedge core_clk) begin
      if (rx_valid && !line_done_r && rx_byte != `SE_CHAR_CR && fill_r < 7'(MAX_CHARS)) begin
         line_mem[fill_r[5:0]] <= rx_byte;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         fill_r      <= '0;
         overflow_r  <= 1'b0;
         line_done_r <= 1'b0;
         line_len_r  <= '0;
      end else if (line_done_r) begin
         if (line_ack) begin
            line_done_r <= 1'b0;
         end
      end else if (rx_valid) begin
         if (rx_byte == `SE_CHAR_CR) begin // R5
            fill_r     <= '0;
            overflow_r <= 1'b0;
            if (!overflow_r) begin // R15
               line_done_r <= 1'b1;
               line_len_r  <= fill_r;
            end
         end else if (fill_r == 7'(MAX_CHARS)) begin
            overflow_r <= 1'b1; // R15
         end else begin
            fill_r <= fill_r + 7'd1;
         end
      end
   end
endmodule
